// ==== core/rf_fast_read_pkg.sv ====
// Behaviour
// - fast multiple read returns each selected block as one 32-bit word
// - block numbers run 00h..1FFh; count field holds blocks minus one
// - at most 32 blocks, one sector; a sector crossing answers an error
// - fast multiple read needs protocol extension flag set, else error
// - fast read answers at double rate and honours the option flag
// - fast read needs subcarrier flag clear, else error
// - read request: flags, code, maker, optional UID, 16-bit first, 8-bit count
// - with option flag each block is preceded by a security status byte
// - status bit 0 is the sector lock; top three bits read zero
// - read errors set error flag with code 03h, 10h or 15h
// - busy mode drives activity pin low from SOF to response end
// - write-in-progress mode leaves activity pin released for these commands
// - initiated inventory is ignored unless the armed flag is set
// - initiated inventory needs inventory flag set and runs anticollision
// - inventory request: flags, code, maker, optional AFI, mask length, mask
// - any error in initiated inventory gives no response
// - inventory and initiate answer flags, DSFID, 64-bit UID
// - in busy mode pin stays low until power-off or the end of the next request if slot never comes
// - initiate sets armed flag and answers only in ready state
// - initiate only non-addressed, select and address clear; errors silent
// - power loss clears the armed flag
package rf_fast_read_pkg;
	localparam logic [7:0] CMD_FAST_READ = 8'hC3;
	localparam logic [7:0] CMD_INV_INIT = 8'hD1;
	localparam logic [7:0] CMD_INITIATE = 8'hD2;
	localparam int FL_SUBCARRIER = 0;
	localparam int FL_INVENTORY = 2;
	localparam int FL_PROT_EXT = 3;
	localparam int FL_SELECT = 4;
	localparam int FL_AFI = 4;
	localparam int FL_ADDRESS = 5;
	localparam int FL_ONE_SLOT = 5;
	localparam int FL_OPTION = 6;
	localparam logic [7:0] RSP_OK = 8'h00;
	localparam logic [7:0] RSP_ERR = 8'h01;
	localparam logic [7:0] ERR_OPTION = 8'h03;
	localparam logic [7:0] ERR_ADDR = 8'h10;
	localparam logic [7:0] ERR_RDPROT = 8'h15;
	localparam logic [8:0] BLK_LAST = 9'h1FF;
	localparam logic [8:0] SECTOR_LAST = 9'h01F;
	localparam int SECTOR_LSB = 5;
	localparam int UID_LSB = 24;
	localparam logic [3:0] OFS_NOUID = 4'h3;
	localparam logic [3:0] OFS_UID = 4'hB;
	localparam logic [4:0] RD_TAIL = 5'h3;
	localparam logic [4:0] HDR_BYTES = 5'h3;
	localparam logic [7:0] MASK_MAX = 8'h40;
	localparam logic [7:0] MASK_MAX16 = 8'h3C;
	localparam logic [3:0] IDENT_BYTES = 4'hA;
	localparam logic [3:0] ERR_BYTES = 4'h2;
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int CFG_BUSY = 0;
	localparam int CFG_DSFID = 8;
	localparam int CFG_AFI = 16;
	localparam int ST_ARMED = 0;
	localparam int ST_ACTIVE = 1;
	localparam int ST_SLOT = 2;
	localparam int ST_ERR = 8;
	localparam logic CFG_BUSY_RST = 1'b1;
endpackage : rf_fast_read_pkg

// ==== core/rf_fast_read.sv ====
`timescale 1ns/1ns
module rf_fast_read #(
	parameter logic [7:0] MFG_CODE = 8'h5A, // arbitrary value
	parameter int BUF_DEPTH = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// request bytes from the rf receiver
	input wire logic reqSof,
	input wire logic reqValid,
	input wire logic [7:0] reqByte,
	input wire logic reqEof,
	input wire logic reqCrcOk,
	// response bytes to the rf transmitter
	input wire logic rspReady,
	output logic rspValid,
	output logic [7:0] rspByte,
	output logic rspStart,
	output logic rspLast,
	output logic rspFast,
	// memory read port
	output logic memRd,
	output logic [8:0] memAddr,
	input wire logic [31:0] memData,
	input wire logic memLocked,
	input wire logic [3:0] memSecCtl,
	input wire logic memRdProt,
	// tag state
	input wire logic [63:0] uid,
	input wire logic tagReady,
	input wire logic fastInitSet,
	input wire logic slotMarker,
	input wire logic rfPowerOff,
	// activity pin, open drain
	output logic actOut,
	output logic actOe
);
	if (BUF_DEPTH < 14 || BUF_DEPTH > 30) begin : g_chk
		$error("BUF_DEPTH must be 14..30");
	end

	localparam int UID_BYTES_HI = 10;
	typedef enum logic [2:0] {S_IDLE, S_RECV, S_FETCH, S_LOAD, S_RESP, S_SLOT} state_e;
	typedef struct packed {
		state_e state;
		logic [BUF_DEPTH-1:0][7:0] reqBuf;
		logic [4:0] cnt;
		logic [79:0] sh;
		logic [3:0] left;
		logic [5:0] blkLeft;
		logic [8:0] blkAddr;
		logic [3:0] sector;
		logic opt;
		logic first;
		logic lastChunk;
		logic [7:0] cmd;
		logic [3:0] slotCnt;
		logic [3:0] mySlot;
		logic armed;
		logic active;
		logic busyMode;
		logic [7:0] dsfid;
		logic [7:0] afi;
		logic [7:0] lastErr;
		logic [1:0] pwr;
		logic rspValid;
		logic rspStart;
		logic rspLast;
		logic rspFast;
		logic memRd;
		logic [8:0] memAddr;
		logic actOut;
		logic actOe;
		logic [31:0] regRdata;
	} st_s;

	st_s r;
	st_s next_r;

	always_comb begin
		logic [7:0] fl;
		logic [3:0] ro;
		logic [3:0] mo;
		logic [15:0] fb;
		logic [7:0] nb;
		logic [7:0] ml;
		logic [63:0] mval;
		logic [63:0] mones;
		logic [63:0] suid;
		logic [39:0] w40;
		logic [7:0] stat;
		logic [4:0] need;
		logic [7:0] ecode;
		logic [9:0] endBlk;
		logic [8:0] secEnd;
		logic inv;
		fl = r.reqBuf[0];
		ro = fl[rf_fast_read_pkg::FL_ADDRESS] ? rf_fast_read_pkg::OFS_UID
			: rf_fast_read_pkg::OFS_NOUID;
		fb = {r.reqBuf[ro+4'h1], r.reqBuf[ro]};
		nb = r.reqBuf[ro+4'h2];
		mo = fl[rf_fast_read_pkg::FL_AFI] ? 4'h4 : 4'h3;
		ml = r.reqBuf[mo];
		mval = 64'(r.reqBuf >> ({4'h0, mo} * 8'h08 + 8'h08));
		mones = (ml >= rf_fast_read_pkg::MASK_MAX) ? '1 : ((64'h1 << ml) - 64'h1);
		suid = uid >> ml;
		need = 5'(mo) + 5'h1 + 5'((9'(ml) + 9'h7) >> 3);
		endBlk = 10'(fb[8:0]) + 10'(nb);
		secEnd = 9'(fb[rf_fast_read_pkg::SECTOR_LSB-1:0]) + 9'(nb);
		stat = {3'b000, memSecCtl, memLocked};
		w40 = r.opt ? {memData, stat} : {8'h00, memData};
		ecode = 8'h00;
		inv = 1'b0;
		next_r = r;
		if (ce) begin
			next_r.pwr = {r.pwr[0], rfPowerOff};
			next_r.memRd = 1'b0;
			next_r.regRdata = '0;
			if (regWr && regAddr == rf_fast_read_pkg::REG_CFG) begin
				next_r.busyMode = regWdata[rf_fast_read_pkg::CFG_BUSY];
				next_r.dsfid = regWdata[rf_fast_read_pkg::CFG_DSFID +: 8];
				next_r.afi = regWdata[rf_fast_read_pkg::CFG_AFI +: 8];
			end
			if (regRd) begin
				case (regAddr)
					rf_fast_read_pkg::REG_CFG: begin
						next_r.regRdata[rf_fast_read_pkg::CFG_BUSY] = r.busyMode;
						next_r.regRdata[rf_fast_read_pkg::CFG_DSFID +: 8] = r.dsfid;
						next_r.regRdata[rf_fast_read_pkg::CFG_AFI +: 8] = r.afi;
					end
					rf_fast_read_pkg::REG_STATUS: begin
						next_r.regRdata[rf_fast_read_pkg::ST_ARMED] = r.armed;
						next_r.regRdata[rf_fast_read_pkg::ST_ACTIVE] = r.active;
						next_r.regRdata[rf_fast_read_pkg::ST_SLOT] = (r.state == S_SLOT);
						next_r.regRdata[rf_fast_read_pkg::ST_ERR +: 8] = r.lastErr;
					end
					default: next_r.regRdata = '0;
				endcase
			end
			// clear first so any arming in the same cycle wins
			if (r.pwr[1]) begin
				next_r.armed = 1'b0;
			end
			if (fastInitSet) begin
				next_r.armed = 1'b1;
			end
			case (r.state)
				S_IDLE, S_SLOT: begin
					if (reqSof) begin
						next_r.state = S_RECV;
						next_r.cnt = '0;
						next_r.active = 1'b1;
					end else if (r.state == S_SLOT && slotMarker) begin
						next_r.slotCnt = r.slotCnt + 4'h1;
						if (r.slotCnt + 4'h1 == r.mySlot) begin
							inv = 1'b1;
						end
					end
				end
				S_RECV: begin
					if (reqValid && r.cnt != 5'(BUF_DEPTH + 1)) begin
						if (r.cnt < 5'(BUF_DEPTH)) begin
							next_r.reqBuf[r.cnt] = reqByte;
						end
						next_r.cnt = r.cnt + 5'h1;
					end
					if (reqEof) begin
						// anything not ours or silently refused just releases the pin
						next_r.state = S_IDLE;
						next_r.active = 1'b0;
						next_r.cmd = r.reqBuf[1];
						if (reqCrcOk && r.cnt >= rf_fast_read_pkg::HDR_BYTES
							&& r.reqBuf[2] == MFG_CODE) begin
							case (r.reqBuf[1])
								rf_fast_read_pkg::CMD_FAST_READ: begin
									if (!fl[rf_fast_read_pkg::FL_ADDRESS]
										|| r.reqBuf[UID_BYTES_HI:3] == uid) begin
										next_r.active = 1'b1;
										next_r.rspFast = 1'b1;
										next_r.opt = fl[rf_fast_read_pkg::FL_OPTION];
										if (r.cnt != 5'(ro) + rf_fast_read_pkg::RD_TAIL
											|| fl[rf_fast_read_pkg::FL_SUBCARRIER]
											|| !fl[rf_fast_read_pkg::FL_PROT_EXT]) begin
											ecode = rf_fast_read_pkg::ERR_OPTION;
										end else if (fb[15:9] != '0
											|| endBlk > 10'(rf_fast_read_pkg::BLK_LAST)
											|| secEnd > rf_fast_read_pkg::SECTOR_LAST) begin
											ecode = rf_fast_read_pkg::ERR_ADDR;
										end else begin
											next_r.state = S_FETCH;
											next_r.blkAddr = fb[8:0];
											next_r.blkLeft = 6'(nb) + 6'h1;
											next_r.sector = fb[8:rf_fast_read_pkg::SECTOR_LSB];
											next_r.first = 1'b1;
										end
									end
								end
								rf_fast_read_pkg::CMD_INV_INIT: begin
									if (r.armed
										&& fl[rf_fast_read_pkg::FL_INVENTORY]
										&& r.cnt == need
										&& ml <= (fl[rf_fast_read_pkg::FL_ONE_SLOT]
											? rf_fast_read_pkg::MASK_MAX
											: rf_fast_read_pkg::MASK_MAX16)
										&& (!fl[rf_fast_read_pkg::FL_AFI] || r.reqBuf[3] == 8'h00
											|| r.reqBuf[3] == r.afi)
										&& ((uid ^ mval) & mones) == '0) begin
										next_r.rspFast = 1'b0;
										next_r.active = 1'b1;
										next_r.mySlot = fl[rf_fast_read_pkg::FL_ONE_SLOT]
											? 4'h0 : suid[3:0];
										next_r.slotCnt = '0;
										if (fl[rf_fast_read_pkg::FL_ONE_SLOT] || suid[3:0] == 4'h0) begin
											inv = 1'b1;
										end else begin
											next_r.state = S_SLOT;
										end
									end
								end
								rf_fast_read_pkg::CMD_INITIATE: begin
									if (!fl[rf_fast_read_pkg::FL_SELECT]
										&& !fl[rf_fast_read_pkg::FL_ADDRESS]
										&& r.cnt == rf_fast_read_pkg::HDR_BYTES) begin
										next_r.armed = 1'b1;
										next_r.rspFast = 1'b0;
										if (tagReady) begin
											next_r.active = 1'b1;
											inv = 1'b1;
										end
									end
								end
								default: next_r.state = S_IDLE;
							endcase
						end
					end
				end
				S_FETCH: begin
					next_r.memRd = 1'b1;
					next_r.memAddr = r.blkAddr;
					next_r.state = S_LOAD;
				end
				S_LOAD: begin
					// protection is per sector, so the first block decides for all
					if (r.first && memRdProt) begin
						ecode = rf_fast_read_pkg::ERR_RDPROT;
					end else begin
						next_r.sh = {40'h0, w40} << (r.first ? 8 : 0);
						next_r.left = 4'h4 + 4'(r.opt) + 4'(r.first);
						next_r.blkLeft = r.blkLeft - 6'h1;
						next_r.blkAddr = r.blkAddr + 9'h1;
						next_r.lastChunk = (r.blkLeft == 6'h1);
						next_r.first = 1'b0;
						next_r.rspStart = r.first;
						next_r.rspValid = 1'b1;
						next_r.state = S_RESP;
					end
				end
				S_RESP: begin
					if (rspReady) begin
						next_r.sh = r.sh >> 8;
						next_r.left = r.left - 4'h1;
						next_r.rspStart = 1'b0;
						if (r.left == 4'h1) begin
							next_r.rspValid = 1'b0;
							next_r.state = r.lastChunk ? S_IDLE : S_FETCH;
							next_r.active = !r.lastChunk;
						end
					end
				end
				default: next_r.state = S_IDLE;
			endcase
			if (ecode != 8'h00) begin
				next_r.sh = {64'h0, ecode, rf_fast_read_pkg::RSP_ERR};
				next_r.left = rf_fast_read_pkg::ERR_BYTES;
				next_r.lastErr = ecode;
				next_r.lastChunk = 1'b1;
			end
			if (inv) begin
				next_r.sh = {uid, r.dsfid, rf_fast_read_pkg::RSP_OK};
				next_r.left = rf_fast_read_pkg::IDENT_BYTES;
				next_r.lastChunk = 1'b1;
			end
			if (ecode != 8'h00 || inv) begin
				next_r.state = S_RESP;
				next_r.rspValid = 1'b1;
				next_r.rspStart = 1'b1;
			end
			if (r.pwr[1]) begin
				next_r.state = S_IDLE;
				next_r.active = 1'b0;
				next_r.rspValid = 1'b0;
				next_r.rspStart = 1'b0;
			end
			next_r.rspLast = next_r.rspValid && next_r.left == 4'h1 && next_r.lastChunk;
			next_r.actOut = 1'b0;
			// write-in-progress mode never drives the pin for these commands
			next_r.actOe = next_r.busyMode && next_r.active;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.busyMode <= rf_fast_read_pkg::CFG_BUSY_RST;
		end else begin
			r <= next_r;
		end
	end

	assign regRdata = r.regRdata;
	assign rspValid = r.rspValid;
	assign rspByte = r.sh[7:0];
	assign rspStart = r.rspStart;
	assign rspLast = r.rspLast;
	assign rspFast = r.rspFast;
	assign memRd = r.memRd;
	assign memAddr = r.memAddr;
	assign actOut = r.actOut;
	assign actOe = r.actOe;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_armGate;
		rspStart && r.cmd == rf_fast_read_pkg::CMD_INV_INIT |-> r.armed;
	endproperty
	a_armGate: assert property (p_armGate) else $error("inventory answered unarmed");

	property p_pwrClear;
		ce && r.pwr[1] && !fastInitSet && !(r.state == S_RECV && reqEof) |=> !r.armed;
	endproperty
	a_pwrClear: assert property (p_pwrClear) else $error("armed survived power-off");

	property p_busyLow;
		r.busyMode && rspValid |-> actOe && !actOut;
	endproperty
	a_busyLow: assert property (p_busyLow) else $error("pin not low during response");

	property p_wipRel;
		!r.busyMode ##1 !r.busyMode |-> !actOe;
	endproperty
	a_wipRel: assert property (p_wipRel) else $error("pin driven in wip mode");

	property p_fastRate;
		rspStart && r.cmd == rf_fast_read_pkg::CMD_FAST_READ |-> rspFast;
	endproperty
	a_fastRate: assert property (p_fastRate) else $error("read not at double rate");

	property p_silentErr;
		rspStart && rspByte == rf_fast_read_pkg::RSP_ERR |-> r.cmd == rf_fast_read_pkg::CMD_FAST_READ;
	endproperty
	a_silentErr: assert property (p_silentErr) else $error("error answer for silent cmd");

	property p_blkRange;
		memRd |-> r.state == S_LOAD && memAddr == r.blkAddr && r.blkLeft != 6'h0;
	endproperty
	a_blkRange: assert property (p_blkRange) else $error("block out of range");

	property p_oneSector;
		memRd |-> memAddr[8:rf_fast_read_pkg::SECTOR_LSB] == r.sector;
	endproperty
	a_oneSector: assert property (p_oneSector) else $error("read crossed sector");

	c_read: cover property (rspStart && r.cmd == rf_fast_read_pkg::CMD_FAST_READ && r.opt);
	c_inv: cover property (rspStart && r.cmd == rf_fast_read_pkg::CMD_INV_INIT);
	c_slot: cover property (r.state == S_SLOT ##[1:50] rspStart);
	c_err: cover property (rspStart && rspByte == rf_fast_read_pkg::RSP_ERR);
endmodule : rf_fast_read

// ==== verification/rf_reader_model.sv ====
`timescale 1ns/1ns
module rf_reader_model (
	// clock
	input wire logic clk_sys,
	// request to the tag
	output logic reqSof,
	output logic reqValid,
	output logic [7:0] reqByte,
	output logic reqEof,
	output logic reqCrcOk,
	// response from the tag
	output logic rspReady,
	input wire logic rspValid,
	input wire logic [7:0] rspByte,
	input wire logic rspStart,
	input wire logic rspLast,
	input wire logic rspFast
);
	logic slow = 1'b0;
	logic done = 1'b0;
	logic startErr = 1'b0;
	logic fast = 1'b0;
	logic [7:0] rx[$];
	initial begin
		reqSof = 1'b0;
		reqValid = 1'b0;
		reqByte = 8'hA5;
		reqEof = 1'b0;
		reqCrcOk = 1'b0;
		rspReady = 1'b0;
	end
	// slow mode drops ready every other cycle
	always @(posedge clk_sys) begin
		rspReady <= slow ? ~rspReady : 1'b1;
		if (rspValid && rspReady) begin
			// only the first byte of a frame may carry the start mark
			if (rspStart != (rx.size() == 0)) startErr <= 1'b1;
			rx.push_back(rspByte);
			fast <= rspFast;
			done <= rspLast;
		end
	end
	// fields go out in the order the caller built them
	task automatic send(input logic [7:0] q[$]);
		rx.delete();
		done <= 1'b0;
		startErr <= 1'b0;
		@(posedge clk_sys);
		reqSof <= 1'b1;
		@(posedge clk_sys);
		reqSof <= 1'b0;
		foreach (q[i]) begin
			reqValid <= 1'b1;
			reqByte <= q[i];
			@(posedge clk_sys);
			reqValid <= 1'b0;
			// idle bus must not look like the last byte
			reqByte <= ~q[i];
			@(posedge clk_sys);
		end
		reqEof <= 1'b1;
		reqCrcOk <= 1'b1;
		@(posedge clk_sys);
		reqEof <= 1'b0;
		reqCrcOk <= 1'b0;
	endtask : send
endmodule : rf_reader_model

// ==== verification/rf_fast_read_and_initiated_inventory_tb.sv ====
`timescale 1ns/1ns
module rf_fast_read_and_initiated_inventory_tb;
	typedef logic [7:0] bytes_t[$];
	localparam logic [7:0] MFG = 8'h3C; // arbitrary maker value
	localparam logic [7:0] FRD = rf_fast_read_pkg::CMD_FAST_READ;
	localparam logic [7:0] INV = rf_fast_read_pkg::CMD_INV_INIT;
	localparam logic [7:0] INI = rf_fast_read_pkg::CMD_INITIATE;
	localparam logic [63:0] UID = 64'h0123_4567_89AB_CDE3;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] regAddr = 4'h0;
	logic [31:0] regWdata = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdata, memData, v;
	logic reqSof, reqValid, reqEof, reqCrcOk, rspReady, rspValid, rspStart, rspLast, rspFast;
	logic [7:0] reqByte, rspByte;
	logic memRd, memLocked, actOut, actOe;
	logic [8:0] memAddr;
	logic memRdProt = 1'b0;
	logic tagReady = 1'b1;
	logic rfPowerOff = 1'b0;
	logic slotMarker = 1'b0;
	logic fastInitSet = 1'b0;
	logic [3:0] memSecCtl;
	int err_count = 0;
	int checks = 0;
	bytes_t e, nil;
	logic [7:0] fls[5] = '{8'h00, 8'h09, 8'h08, 8'h08, 8'h08};
	logic [15:0] bks[5] = '{16'h0002, 16'h0002, 16'h001F, 16'h0200, 16'h0002};
	logic [7:0] cns[5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
	logic [7:0] codes[5] = '{8'h03, 8'h03, 8'h10, 8'h10, 8'h15};
	// block data carries its own address so a misfetch shows
	assign memData = {16'hBEEF, 7'h00, memAddr};
	assign memLocked = memAddr[5];
	assign memSecCtl = memAddr[3:0];
	always #4 clk_sys = ~clk_sys;
	rf_fast_read #(.MFG_CODE(MFG)) rf_fast_read_i (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .reqSof(reqSof), .reqValid(reqValid), .reqByte(reqByte),
		.reqEof(reqEof), .reqCrcOk(reqCrcOk), .rspReady(rspReady), .rspValid(rspValid),
		.rspByte(rspByte), .rspStart(rspStart), .rspLast(rspLast), .rspFast(rspFast),
		.memRd(memRd), .memAddr(memAddr), .memData(memData), .memLocked(memLocked),
		.memSecCtl(memSecCtl), .memRdProt(memRdProt), .uid(UID), .tagReady(tagReady),
		.fastInitSet(fastInitSet), .slotMarker(slotMarker), .rfPowerOff(rfPowerOff),
		.actOut(actOut), .actOe(actOe));
	rf_reader_model rf_reader_model_i (.clk_sys(clk_sys), .reqSof(reqSof), .reqValid(reqValid),
		.reqByte(reqByte), .reqEof(reqEof), .reqCrcOk(reqCrcOk), .rspReady(rspReady),
		.rspValid(rspValid), .rspByte(rspByte), .rspStart(rspStart), .rspLast(rspLast),
		.rspFast(rspFast));
	task automatic close_out();
		if (err_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task automatic chkFrame(input bytes_t x, input bytes_t g);
		checks++;
		if (g.size() != x.size()) begin
			err_count++;
			$display("unexpected response length expected %0d seen %0d", x.size(), g.size());
		end else begin
			foreach (x[i]) if (g[i] !== x[i]) begin
				err_count++;
				$display("unexpected response byte %0d expected %h seen %h", i, x[i], g[i]);
			end
		end
	endtask : chkFrame
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		@(negedge clk_sys);
		d = regRdata;
	endtask : rd
	function automatic bytes_t fr(input logic [7:0] f, input logic [15:0] b, input logic [7:0] n);
		return '{f, FRD, MFG, b[7:0], b[15:8], n};
	endfunction : fr
	task automatic expRead(input logic [8:0] f, input int n, input logic opt);
		e = '{8'h00};
		for (int b = 0; b < n; b++) begin
			logic [8:0] a;
			logic [31:0] w;
			a = f + 9'(b);
			w = {16'hBEEF, 7'h00, a};
			if (opt) e.push_back({3'h0, a[3:0], a[5]});
			for (int k = 0; k < 4; k++) e.push_back(w[8*k+:8]);
		end
	endtask : expRead
	task automatic expIdent();
		e = '{8'h00, 8'h7C};
		for (int k = 0; k < 8; k++) e.push_back(UID[8*k+:8]);
	endtask : expIdent
	task automatic run(input bytes_t q, input bytes_t x, input logic mid, input logic fin);
		fork
			rf_reader_model_i.send(q);
			begin
				repeat (4) @(negedge clk_sys);
				chk("activity pin in frame", {31'h0, mid}, {31'h0, actOe});
				chk("activity pin level", 32'h0, {31'h0, actOut});
			end
		join
		// no answer within the slot span counts as silence
		for (int i = 0; i < 600 && !rf_reader_model_i.done; i++) @(posedge clk_sys);
		repeat (3) @(negedge clk_sys);
		chkFrame(x, rf_reader_model_i.rx);
		chk("start mark", 32'h0, {31'h0, rf_reader_model_i.startErr});
		if (x.size() > 2 && x[0] === 8'h00)
			chk("double rate", {31'h0, q[1] == FRD}, {31'h0, rf_reader_model_i.fast});
		chk("activity pin after frame", {31'h0, fin}, {31'h0, actOe});
	endtask : run
	initial begin
		#400000;
		err_count++;
		close_out();
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		rd(4'h0, v);
		chk("cfg reset", 32'h0000_0001, v);
		rd(4'h4, v);
		chk("status reset", 32'h0, v);
		rd(4'h8, v);
		chk("unmapped read", 32'h0, v);
		wr(4'h0, 32'h0000_7C01);
		run('{8'h24, INV, MFG, 8'h00}, nil, 1'b1, 1'b0);
		expIdent();
		run('{8'h00, INI, MFG}, e, 1'b1, 1'b0);
		rd(4'h4, v);
		chk("armed", 32'h1, v & 32'h1);
		run('{8'h10, INI, MFG}, nil, 1'b1, 1'b0);
		run('{8'h20, INV, MFG, 8'h00}, nil, 1'b1, 1'b0);
		run('{8'h24, INV, MFG, 8'h00}, e, 1'b1, 1'b0);
		run('{8'h34, INV, MFG, 8'h00, 8'h00}, e, 1'b1, 1'b0);
		rf_reader_model_i.slow = 1'b1;
		expRead(9'h020, 32, 1'b0);
		run(fr(8'h08, 16'h0020, 8'h1F), e, 1'b1, 1'b0);
		rf_reader_model_i.slow = 1'b0;
		expRead(9'h021, 2, 1'b1);
		run(fr(8'h48, 16'h0021, 8'h01), e, 1'b1, 1'b0);
		expRead(9'h000, 1, 1'b1);
		run(fr(8'h48, 16'h0000, 8'h00), e, 1'b1, 1'b0);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_sys);
			memRdProt <= (i == 4);
			e = '{8'h01, codes[i]};
			run(fr(fls[i], bks[i], cns[i]), e, 1'b1, 1'b0);
		end
		@(posedge clk_sys);
		memRdProt <= 1'b0;
		wr(4'h0, 32'h0000_7C00);
		expRead(9'h002, 1, 1'b0);
		run(fr(8'h08, 16'h0002, 8'h00), e, 1'b0, 1'b0);
		wr(4'h0, 32'h0000_7C01);
		// uid low nibble is 3, so the third marker opens our slot
		expIdent();
		run('{8'h04, INV, MFG, 8'h00}, nil, 1'b1, 1'b1);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys);
			slotMarker <= 1'b1;
			@(posedge clk_sys);
			slotMarker <= 1'b0;
		end
		repeat (16) @(negedge clk_sys);
		chkFrame(e, rf_reader_model_i.rx);
		chk("activity pin after slot", 32'h0, {31'h0, actOe});
		// slot never marked: pin is held until the field drops
		run('{8'h04, INV, MFG, 8'h00}, nil, 1'b1, 1'b1);
		@(posedge clk_sys);
		rfPowerOff <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rfPowerOff <= 1'b0;
		repeat (4) @(negedge clk_sys);
		chk("activity pin at power-off", 32'h0, {31'h0, actOe});
		rd(4'h4, v);
		chk("armed after power-off", 32'h0, v & 32'h1);
		run('{8'h24, INV, MFG, 8'h00}, nil, 1'b1, 1'b0);
		@(posedge clk_sys);
		fastInitSet <= 1'b1;
		@(posedge clk_sys);
		fastInitSet <= 1'b0;
		rd(4'h4, v);
		chk("armed by fast initiate", 32'h1, v & 32'h1);
		run('{8'h24, INV, MFG, 8'h00}, e, 1'b1, 1'b0);
		close_out();
	end
endmodule : rf_fast_read_and_initiated_inventory_tb
